// *** rtl/sag_top.sv ***
// Sample activity gate sequencer: per channel, schedules measurement,
// calibration and cleaning, gated by a process-access input, and drives
// measurement-active and sample-request outputs. APB register slave.
// Assumes process-access pins asynchronous to pclk, APB master on pclk.
//
// Overview of operation
// - Activities start only while access input active.
// - Pending activities wait, kept, while access inactive.
// - Configured schedule sets order; access only gates.
// - Measurement-active high exactly during measurement runs.
// - Sample request asserted ahead of every activity.
// - Lead time delays start, counted from request.
// - Request duration capped at lead plus activity.
// - Continuous mode starts measurement once access active.
// - Due calibration or cleaning runs before measurement.
// - Continuous mode repeats measurements while access active.
// - Each channel binds selectable input; second optional.
// - Second channel has own active and request outputs.
// - Each access input has selectable active polarity.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "sag_defs.svh"
module sag_top #(
  parameter int TICK_CYCLES = `SAG_TICK_PERIOD_NS / `SAG_CLK_PERIOD_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  access_in,
  output logic      [1:0]  meas_active,
  output logic      [1:0]  sample_req
);
  import sag_pkg::*;

  logic [31:0] ctrl;
  sag_sec_t    lead_time;
  sag_sec_t    dur       [2];
  sag_sec_t    adur      [3];
  sag_sec_t    ivl       [3];
  logic [1:0]  lvl;
  logic        tick;
  logic [1:0]  ch_on;
  logic [1:0]  acc;
  logic [1:0]  start;
  sag_act_e    next_act  [2];
  logic [2:0]  expire    [2];
  logic [2:0]  pend      [2];
  sag_sec_t    tmr       [2][3];
  sag_state_e  state     [2];
  sag_act_e    act       [2];
  sag_sec_t    lead_cnt  [2];
  sag_sec_t    run_cnt   [2];
  logic [16:0] sreq_cnt  [2];
  logic [31:0] rd_val;
  logic        hit;
  logic        wr;

  sag_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (access_in),
    .q       (lvl)
  );

  sag_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  function automatic sag_act_e pick(input logic [2:0] p);
    // Calibration, then cleaning, ahead of measurement
    if (p[SAG_CAL])
      return SAG_CAL;
    else if (p[SAG_CLEAN])
      return SAG_CLEAN;
    return SAG_MEAS;
  endfunction : pick

  function automatic logic [16:0] sreq_len(input sag_sec_t d,
                                           input sag_sec_t l,
                                           input sag_sec_t a);
    logic [16:0] cap;
    cap = {1'b0, l} + {1'b0, a};
    return ({1'b0, d} < cap) ? {1'b0, d} : cap;
  endfunction : sreq_len

  // Register interface
  assign pready = 1'b1;
  assign wr     = psel & penable & pwrite;
  assign hit    = (paddr == `SAG_OFF_CTRL) || (paddr == `SAG_OFF_LEAD) ||
                  (paddr == `SAG_OFF_DUR) || (paddr == `SAG_OFF_STATUS) ||
                  (paddr == `SAG_OFF_ACT) ||
                  (paddr == `SAG_OFF_ACT + 8'h04) ||
                  (paddr == `SAG_OFF_ACT + 8'h08);
  assign pslverr = psel & penable & !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= `SAG_CTRL_RST;
      lead_time <= `SAG_TIME_RST;
      for (int c = 0; c < 2; c++)
        dur[c] <= `SAG_TIME_RST;
      for (int k = 0; k < 3; k++) begin
        adur[k] <= `SAG_TIME_RST;
        ivl[k]  <= `SAG_TIME_RST;
      end
    end else if (wr) begin
      if (paddr == `SAG_OFF_CTRL)
        ctrl <= pwdata & `SAG_CTRL_MASK;
      if (paddr == `SAG_OFF_LEAD)
        lead_time <= pwdata[15:0];
      if (paddr == `SAG_OFF_DUR) begin
        dur[0] <= pwdata[15:0];
        dur[1] <= pwdata[31:16];
      end
      for (int k = 0; k < 3; k++) begin
        if (paddr == `SAG_OFF_ACT + 8'(4 * k)) begin
          adur[k] <= pwdata[15:0];
          ivl[k]  <= pwdata[31:16];
        end
      end
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (paddr == `SAG_OFF_CTRL)
      rd_val = ctrl;
    if (paddr == `SAG_OFF_LEAD)
      rd_val = {16'h0, lead_time};
    if (paddr == `SAG_OFF_DUR)
      rd_val = {dur[1], dur[0]};
    for (int k = 0; k < 3; k++)
      if (paddr == `SAG_OFF_ACT + 8'(4 * k))
        rd_val = {ivl[k], adur[k]};
    if (paddr == `SAG_OFF_STATUS)
      rd_val = {12'h0, state[1], state[0], 1'b0, pend[1], 1'b0, pend[0],
                2'h0, sample_req, meas_active, acc};
  end

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_val;
  end

  // Access gating and scheduling decisions
  assign ch_on = {ctrl[`SAG_CTRL_CH2_EN], 1'b1};

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // Input chosen per channel, polarity per input
      acc[c] = ch_on[c] & (lvl[ctrl[`SAG_CTRL_SEL + c]] ==
                           ctrl[`SAG_CTRL_POL + ctrl[`SAG_CTRL_SEL + c]]);
      next_act[c] = pick(pend[c]);
      start[c] = (state[c] == SAG_IDLE) & acc[c] &
                 ((|pend[c]) | ctrl[`SAG_CTRL_CONT + c]);
      for (int k = 0; k < 3; k++)
        expire[c][k] = tick & ch_on[c] & (ivl[k] != 16'h0) &
                       (tmr[c][k] >= ivl[k] - 16'h1);
    end
  end

  // Interval timers; a zero interval holds that timer, so the activity never falls due
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++)
        for (int k = 0; k < 3; k++)
          tmr[c][k] <= 16'h0;
    end else begin
      for (int c = 0; c < 2; c++)
        for (int k = 0; k < 3; k++)
          if (!ch_on[c] || expire[c][k])
            tmr[c][k] <= 16'h0;
          else if (tick && ivl[k] != 16'h0)
            tmr[c][k] <= tmr[c][k] + 16'h1;
    end
  end

  // Pending work is kept until taken; an expiry wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++)
        pend[c] <= 3'h0;
    end else begin
      for (int c = 0; c < 2; c++)
        for (int k = 0; k < 3; k++)
          pend[c][k] <= expire[c][k] | (pend[c][k] &
                        !(start[c] && next_act[c] == sag_act_e'(k)));
    end
  end

  // Per-channel sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        state[c]    <= SAG_IDLE;
        act[c]      <= SAG_MEAS;
        lead_cnt[c] <= 16'h0;
        run_cnt[c]  <= 16'h0;
      end
      meas_active <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!ch_on[c]) begin
          state[c]       <= SAG_IDLE;
          lead_cnt[c]    <= 16'h0;
          run_cnt[c]     <= 16'h0;
          meas_active[c] <= 1'b0;
        end else begin
          unique case (state[c])
            SAG_IDLE: begin
              if (start[c]) begin
                act[c] <= next_act[c];
                if (ctrl[`SAG_CTRL_SREQ + c]) begin
                  state[c]    <= SAG_LEAD;
                  lead_cnt[c] <= lead_time;
                end else begin
                  state[c]       <= SAG_RUN;
                  run_cnt[c]     <= adur[next_act[c]];
                  meas_active[c] <= (next_act[c] == SAG_MEAS);
                end
              end
            end
            SAG_LEAD: begin
              // Lead elapsed but access gone: hold, do not discard
              if (lead_cnt[c] == 16'h0) begin
                if (acc[c]) begin
                  state[c]       <= SAG_RUN;
                  run_cnt[c]     <= adur[act[c]];
                  meas_active[c] <= (act[c] == SAG_MEAS);
                end
              end else if (tick) begin
                lead_cnt[c] <= lead_cnt[c] - 16'h1;
              end
            end
            SAG_RUN: begin
              // Runs to completion even if access drops meanwhile
              if (run_cnt[c] == 16'h0) begin
                state[c]       <= SAG_IDLE;
                meas_active[c] <= 1'b0;
              end else if (tick) begin
                run_cnt[c] <= run_cnt[c] - 16'h1;
              end
            end
          endcase
        end
      end
    end
  end

  // Sample request, loaded with the capped duration at each start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++)
        sreq_cnt[c] <= 17'h0;
      sample_req <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!ch_on[c]) begin
          sreq_cnt[c]   <= 17'h0;
          sample_req[c] <= 1'b0;
        end else if (start[c] && ctrl[`SAG_CTRL_SREQ + c]) begin
          sreq_cnt[c]   <= sreq_len(dur[c], lead_time,
                                    adur[next_act[c]]);
          sample_req[c] <= (sreq_len(dur[c], lead_time,
                                     adur[next_act[c]]) != 17'h0);
        end else if (tick && sreq_cnt[c] != 17'h0) begin
          sreq_cnt[c]   <= sreq_cnt[c] - 17'h1;
          sample_req[c] <= (sreq_cnt[c] != 17'h1);
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  no_gate_start_a: assert property (
    ($past(state[0]) != SAG_RUN && state[0] == SAG_RUN) |->
      $past(acc[0]))
    else $error("activity started without process access");

  pend_hold_a: assert property (
    (pend[0][SAG_CAL] && !acc[0]) |=> pend[0][SAG_CAL])
    else $error("pending calibration lost while access inactive");

  meas_flag_a: assert property (
    meas_active[0] == (state[0] == SAG_RUN && act[0] == SAG_MEAS) ||
    $past(!ch_on[0]))
    else $error("measurement active does not match measurement run");

  sreq_lead_a: assert property (
    (start[0] && ctrl[`SAG_CTRL_SREQ] && dur[0] != 16'h0 &&
     lead_time != 16'h0) |=> sample_req[0] && state[0] == SAG_LEAD)
    else $error("sample request missing ahead of activity");

  lead_wait_a: assert property (
    (state[0] == SAG_LEAD && lead_cnt[0] != 16'h0) |=>
      state[0] != SAG_RUN)
    else $error("activity started before lead time elapsed");

  sreq_cap_a: assert property (
    (start[0] && ctrl[`SAG_CTRL_SREQ]) |=>
      sreq_cnt[0] <= {1'b0, lead_time} + {1'b0, adur[act[0]]})
    else $error("sample request longer than lead plus activity");

  cont_start_a: assert property (
    (state[0] == SAG_IDLE && acc[0] && ctrl[`SAG_CTRL_CONT] &&
     pend[0] == 3'h0) |=> state[0] != SAG_IDLE && act[0] == SAG_MEAS)
    else $error("continuous mode did not start measurement");

  cal_first_a: assert property (
    (start[0] && pend[0][SAG_CAL]) |=> act[0] == SAG_CAL)
    else $error("due calibration not run first");

  back_to_back_a: assert property (
    (state[0] == SAG_RUN && run_cnt[0] == 16'h0) |=>
      state[0] == SAG_IDLE ##1 (!$past(acc[0]) ||
      !ctrl[`SAG_CTRL_CONT] || state[0] != SAG_IDLE))
    else $error("idle gap between continuous measurements");

  ch2_off_a: assert property (
    !ch_on[1] |=> !meas_active[1] && !sample_req[1])
    else $error("disabled second channel is active");

  meas_run_c: cover property (state[0] == SAG_RUN && act[0] == SAG_MEAS);
  cal_run_c: cover property (state[0] == SAG_RUN && act[0] == SAG_CAL);
  lead_hold_c: cover property (
    state[0] == SAG_LEAD && lead_cnt[0] == 16'h0 && !acc[0]);
  ch2_meas_c: cover property (meas_active[1]);
endmodule : sag_top

// *** common/sag_defs.svh ***
// Offsets, field positions, reset values and timing figures of the
// sample activity gate sequencer. Definitions only.
`ifndef SAG_DEFS_SVH
`define SAG_DEFS_SVH

`define SAG_CLK_PERIOD_NS   10
`define SAG_TICK_PERIOD_NS  1000000000

`define SAG_OFF_CTRL        8'h00
`define SAG_OFF_LEAD        8'h04
`define SAG_OFF_DUR         8'h08
`define SAG_OFF_ACT         8'h0c
`define SAG_OFF_STATUS      8'h18

`define SAG_CTRL_CH2_EN     0
`define SAG_CTRL_POL        1
`define SAG_CTRL_SEL        4
`define SAG_CTRL_CONT       8
`define SAG_CTRL_SREQ       12
`define SAG_CTRL_MASK       32'h0000_3337
`define SAG_CTRL_RST        32'h0000_0026

`define SAG_TIME_RST        16'h0000
`endif

// *** common/sag_pkg.sv ***
// Types shared by the sequencer modules.
package sag_pkg;
  typedef logic [15:0] sag_sec_t;
  typedef enum logic [1:0] {SAG_IDLE, SAG_LEAD, SAG_RUN} sag_state_e;
  typedef enum logic [1:0] {SAG_MEAS, SAG_CAL, SAG_CLEAN} sag_act_e;
endpackage : sag_pkg

// *** rtl/sag_sync.sv ***
// Two-stage synchroniser for the process-access pins.
// Assumes the pins are asynchronous to pclk.
`timescale 1ns/1ps
module sag_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] d,
  output logic      [1:0] q
);
  import sag_pkg::*;

  logic [1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 2'h0;
      q    <= 2'h0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

  sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> q == $past(d, 2))
    else $error("synchroniser delay is not two cycles");
endmodule : sag_sync

// *** rtl/sag_tick.sv ***
// One-second timebase: a one-cycle pulse every TICK_CYCLES clocks.
// Assumes a free-running pclk.
`timescale 1ns/1ps
`include "sag_defs.svh"
module sag_tick #(
  parameter int TICK_CYCLES = `SAG_TICK_PERIOD_NS / `SAG_CLK_PERIOD_NS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  import sag_pkg::*;

  logic [26:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 27'h0;
      tick <= 1'b0;
    end else if (cnt == 27'(TICK_CYCLES - 1)) begin
      cnt  <= 27'h0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 27'h1;
      tick <= 1'b0;
    end
  end

  tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick)
    else $error("timebase ticks back to back");
endmodule : sag_tick

// *** verification/sag_ctl_model.sv ***
// External controller that drives the process-access pins.
// Assumes it is clocked by pclk and told the configured polarity.
`timescale 1ns/1ps
module sag_ctl_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] want,
  input  wire logic [1:0] pol,
  input  wire logic [1:0] one_shot,
  input  wire logic [1:0] meas_active,
  output logic      [1:0] access_in
);
  logic [1:0] drop;

  // Single shot: release access while the measurement still runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop <= 2'h0;
    end else begin
      drop <= want & (drop | (one_shot & meas_active));
    end
  end

  assign access_in = ~((want & ~drop) ^ pol);
endmodule : sag_ctl_model

// *** verification/sag_top_tb.sv ***
// Self-checking bench for sag_top: APB register tasks plus a
// controller model on the access pins. Shortened one-second tick.
`timescale 1ns/1ps
`include "sag_defs.svh"
module sag_top_tb;
  import sag_pkg::*;
  localparam int TK = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  access_in, meas_active, sample_req, want, pol, one_shot;
  logic [3:0]  obs;
  int          errors, num_checks, n, m;

  assign obs = {sample_req, meas_active};

  sag_top #(.TICK_CYCLES(TK)) i_sag_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .access_in(access_in), .meas_active(meas_active),
    .sample_req(sample_req));

  sag_ctl_model i_sag_ctl_model (
    .pclk(pclk), .presetn(presetn), .want(want), .pol(pol),
    .one_shot(one_shot), .meas_active(meas_active),
    .access_in(access_in));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  task finish_test;
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, pready, 1'b1);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for one output bit; running out counts as a mismatch
  task wt(input int b, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (n > lim) begin
        errors++;
        $display("Error at %0t: got %h expected %h", $time, obs, v);
        finish_test();
      end
    end while (obs[b] !== v);
    num_checks++;
  endtask : wt

  task quiet(input int b, input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge pclk);
      seen = seen | (obs[b] !== 1'b0);
    end
    chk(32'(seen), 32'h0);
  endtask : quiet

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {want, one_shot} = 4'h0;
    pol = 2'h3;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `SAG_OFF_CTRL, 32'h0);
    chk(rd, `SAG_CTRL_RST);
    apb(0, `SAG_OFF_LEAD, 32'h0);
    chk(rd, 32'h0);
    apb(0, 8'h1c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1, `SAG_OFF_ACT, 32'h0000_0002);
    apb(1, `SAG_OFF_CTRL, 32'h0000_0126);
    quiet(0, 6 * TK);
    want <= 2'h1;
    wt(0, 1, 8);
    wt(0, 0, 3 * TK);
    // First tick of a run may come early: 1..2 tick periods plus a cycle
    chk(32'(n > TK && n <= 2 * TK + 2), 32'h1);
    wt(0, 1, 4);
    one_shot <= 2'h1;
    wt(0, 0, 3 * TK);
    quiet(0, 6 * TK);
    want <= 2'h0;
    one_shot <= 2'h0;
    // Continuous start off while the pin settles to the new polarity
    apb(1, `SAG_OFF_CTRL, 32'h0000_0024);
    pol <= 2'h2;
    apb(1, `SAG_OFF_CTRL, 32'h0000_0124);
    quiet(0, 2 * TK);
    want <= 2'h1;
    wt(0, 1, 8);
    want <= 2'h0;
    wt(0, 0, 3 * TK);
    apb(1, `SAG_OFF_CTRL, 32'h0000_0024);
    pol <= 2'h3;
    apb(1, `SAG_OFF_LEAD, 32'h0000_0002);
    apb(1, `SAG_OFF_DUR, 32'h0003_0064);
    apb(1, `SAG_OFF_CTRL, 32'h0000_1126);
    one_shot <= 2'h1;
    want <= 2'h1;
    wt(2, 1, 8);
    chk(32'(meas_active[0]), 32'h0);
    wt(0, 1, 3 * TK);
    chk(32'(n >= TK && n <= 2 * TK + 3), 32'h1);
    chk(32'(sample_req[0]), 32'h1);
    m = n;
    wt(2, 0, 4 * TK);
    chk(32'(m + n <= 4 * TK + 4), 32'h1);
    want <= 2'h0;
    one_shot <= 2'h0;
    apb(1, `SAG_OFF_CTRL, 32'h0000_2227);
    want <= 2'h2;
    wt(3, 1, 8);
    chk(32'(obs[2] | meas_active[0]), 32'h0);
    wt(1, 1, 3 * TK);
    want <= 2'h0;
    wt(1, 0, 3 * TK);
    // Calibration falls due while access is off: kept, then run first
    apb(1, `SAG_OFF_CTRL, 32'h0000_0026);
    apb(1, `SAG_OFF_ACT + 8'h04, 32'h0003_0001);
    quiet(0, 4 * TK);
    apb(1, `SAG_OFF_ACT + 8'h04, 32'h0000_0001);
    apb(0, `SAG_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0200);
    apb(1, `SAG_OFF_CTRL, 32'h0000_0126);
    want <= 2'h1;
    wt(0, 1, 3 * TK);
    chk(32'(n > 4), 32'h1);
    want <= 2'h0;
    wt(0, 0, 3 * TK);
    finish_test();
  end
endmodule : sag_top_tb
